// [verilog/fdcr_params.svh]
`ifndef FDCR_PARAMS_SVH
`define FDCR_PARAMS_SVH

// register offsets inside the floppy block window
`define FDCR_OFF_STATUS_A       3'h0
`define FDCR_OFF_STATUS_B       3'h1
`define FDCR_OFF_DIGITAL_OUTPUT 3'h2
`define FDCR_OFF_TAPE_DRIVE     3'h3
`define FDCR_OFF_MAIN_STATUS    3'h4
`define FDCR_OFF_DATA_PORT      3'h5
`define FDCR_OFF_RESERVED_SIX   3'h6
`define FDCR_OFF_DIGITAL_INPUT  3'h7

// configuration port pairs: index port, then data port
`define FDCR_CFG_INDEX_A        10'h3f0
`define FDCR_CFG_DATA_A         10'h3f1
`define FDCR_CFG_INDEX_B        10'h370
`define FDCR_CFG_DATA_B         10'h371

// configuration entry and exit keys written to the index port
`define FDCR_CFG_ENTER_KEY      8'h55
`define FDCR_CFG_EXIT_KEY       8'haa

// configuration register indices
`define FDCR_CR_MODE            8'h03
`define FDCR_CR_FORCE           8'h17
`define FDCR_CR_BASE            8'h20

// field positions
`define FDCR_MODE_ENH_BIT       0
`define FDCR_MODE_ENC_BIT       1
`define FDCR_MODE_IDENT_BIT     2
`define FDCR_FORCE_WP_BIT       0

// reset values
`define FDCR_CR_MODE_RST        8'h06
`define FDCR_CR_FORCE_RST       8'h00
`define FDCR_CR_BASE_RST        8'h00
`define FDCR_CR_INDEX_RST       8'h00

// edges after reset release before the port strap is final
`define FDCR_BOOT_WAIT          2'h3

`endif

// [verilog/fdcr_pkg.sv]
package fdcr_pkg;

  // interface mode, one-hot
  typedef enum logic [2:0] {
    FDCR_IF_FIRST  = 3'b001,
    FDCR_IF_SECOND = 3'b010,
    FDCR_IF_THIRD  = 3'b100
  } fdcr_if_mode_t;

  // configuration entry state, one-hot
  typedef enum logic [2:0] {
    FDCR_CS_IDLE   = 3'b001,
    FDCR_CS_KEY    = 3'b010,
    FDCR_CS_ACTIVE = 3'b100
  } fdcr_cfg_state_t;

  // decoded configuration seen by the floppy block
  typedef struct packed {
    logic          enh_floppy;
    fdcr_if_mode_t if_mode;
    logic          force_wp;
    logic          fdc_en;
    logic [6:0]    base;
  } fdcr_cfg_t;

  // one committed host write
  typedef struct packed {
    logic       wr;
    logic [9:0] addr;
    logic [7:0] data;
  } fdcr_wr_t;

  // drive input pins, all active low
  typedef struct packed {
    logic write_protect_n;
    logic index_n;
    logic track_zero_n;
    logic second_drive_present_n;
  } fdcr_disk_t;

  // controller core state on the same clock
  typedef struct packed {
    logic head_inward;
    logic head_side;
    logic step_out;
    logic floppy_irq_out;
    logic drq;
  } fdcr_core_t;

endpackage

// [verilog/fdcr_sync.sv]
`timescale 1ns/10ps
module fdcr_sync #(
  parameter int         W   = 1,
  parameter logic [W-1:0] RST = '0
) (
  input  wire logic         mclk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] stage1;  // first stage, read only by second

  // two flops per bit
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
          stage1[i] <= RST[i];
          q[i]      <= RST[i];
        end else begin
          stage1[i] <= d[i];
          q[i]      <= stage1[i];
        end
      end
    end
  endgenerate
endmodule

// [verilog/fdcr_cfg.sv]
`timescale 1ns/10ps
`include "fdcr_params.svh"
module fdcr_cfg
  import fdcr_pkg::*;
(
  input  wire logic     mclk,
  input  wire logic     rst_n,
  input  wire logic     port_alt,
  input  wire fdcr_wr_t wr,
  output fdcr_cfg_t     cfg,
  output logic          cfg_active
);
  fdcr_cfg_state_t state, next_state;       // entry sequence
  logic [7:0]      index_reg, next_index;   // selected config register
  logic [7:0]      mode_reg, next_mode;     // floppy and interface mode bits
  logic [7:0]      base_reg, next_base;     // base address, addr[9:2]
  logic [7:0]      force_reg, next_force;   // forced status bits
  logic [1:0]      boot_cnt, next_boot_cnt; // strap settle counter
  logic            alt_sel, next_alt_sel;   // captured port strap
  logic            boot_done;
  logic            idx_hit;
  logic            dat_hit;
  fdcr_if_mode_t   mode_dec;               // decoded interface mode

  // port pair follows the strap once it has settled
  assign boot_done = (boot_cnt == `FDCR_BOOT_WAIT);
  assign idx_hit = wr.wr && boot_done &&
                   (wr.addr == (alt_sel ? `FDCR_CFG_INDEX_B : `FDCR_CFG_INDEX_A)); // R02
  assign dat_hit = wr.wr && boot_done &&
                   (wr.addr == (alt_sel ? `FDCR_CFG_DATA_B : `FDCR_CFG_DATA_A)); // R02

  // next state of entry machine and config registers
  always_comb begin
    next_state    = state;
    next_index    = index_reg;
    next_mode     = mode_reg;
    next_base     = base_reg;
    next_force    = force_reg;
    next_boot_cnt = boot_cnt;
    next_alt_sel  = alt_sel;
    // strap keeps tracking until settled
    if (!boot_done) begin
      next_boot_cnt = boot_cnt + 2'h1;
      next_alt_sel  = port_alt;
    end
    case (state)
      FDCR_CS_IDLE: begin
        // first key
        if (idx_hit && wr.data == `FDCR_CFG_ENTER_KEY) begin
          next_state = FDCR_CS_KEY;
        end
      end
      FDCR_CS_KEY: begin
        // second key or fall back
        if (idx_hit) begin
          next_state = (wr.data == `FDCR_CFG_ENTER_KEY) ? FDCR_CS_ACTIVE : FDCR_CS_IDLE;
        end
      end
      FDCR_CS_ACTIVE: begin
        // only here do config writes land
        if (idx_hit) begin
          if (wr.data == `FDCR_CFG_EXIT_KEY) begin
            next_state = FDCR_CS_IDLE;
          end else begin
            next_index = wr.data;
          end
        end else if (dat_hit) begin
          case (index_reg) // R04
            `FDCR_CR_MODE:  next_mode  = wr.data;
            `FDCR_CR_BASE:  next_base  = wr.data; // R03
            `FDCR_CR_FORCE: next_force = wr.data;
            default:        ;
          endcase
        end
      end
      default: next_state = FDCR_CS_IDLE;
    endcase
  end

  // register config state
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state     <= FDCR_CS_IDLE;
      index_reg <= `FDCR_CR_INDEX_RST;
      mode_reg  <= `FDCR_CR_MODE_RST;
      base_reg  <= `FDCR_CR_BASE_RST;
      force_reg <= `FDCR_CR_FORCE_RST;
      boot_cnt  <= 2'h0;
      alt_sel   <= 1'b0;
    end else begin
      state     <= next_state;
      index_reg <= next_index;
      mode_reg  <= next_mode;
      base_reg  <= next_base;
      force_reg <= next_force;
      boot_cnt  <= next_boot_cnt;
      alt_sel   <= next_alt_sel;
    end
  end

  // decode of the interface mode bits
  always_comb begin
    case ({mode_reg[`FDCR_MODE_IDENT_BIT], mode_reg[`FDCR_MODE_ENC_BIT]})
      2'b11:   mode_dec = FDCR_IF_FIRST;  // R06
      2'b01:   mode_dec = FDCR_IF_SECOND; // R07
      2'b00:   mode_dec = FDCR_IF_THIRD;  // R08
      default: mode_dec = FDCR_IF_FIRST;
    endcase
  end
  assign cfg.if_mode = mode_dec;

  // remaining decoded fields
  assign cfg.enh_floppy = mode_reg[`FDCR_MODE_ENH_BIT]; // R05
  assign cfg.force_wp   = force_reg[`FDCR_FORCE_WP_BIT];
  assign cfg.base       = base_reg[7:1];
  assign cfg.fdc_en     = |base_reg[7:1]; // R03
  assign cfg_active     = (state == FDCR_CS_ACTIVE);

  // config registers only move inside config state
  a_cfg_gate: assert property (@(posedge mclk) disable iff (!rst_n) // R04
    ($changed(mode_reg) || $changed(base_reg) || $changed(force_reg))
      |-> $past(state) == FDCR_CS_ACTIVE)
    else $error("config register changed outside config state");

  // floppy block starts disabled
  a_cfg_boot_off: assert property (@(posedge mclk) disable iff (!rst_n) // R03
    (boot_cnt == 2'h0) |-> !cfg.fdc_en)
    else $error("floppy block enabled right after reset");

  // two keys at the index port open config state
  a_cfg_enter: assert property (@(posedge mclk) disable iff (!rst_n) // R02
    (state == FDCR_CS_KEY && idx_hit && wr.data == `FDCR_CFG_ENTER_KEY)
      |=> cfg_active)
    else $error("second key did not open config state");

  c_cfg_enter: cover property (@(posedge mclk) disable iff (!rst_n) $rose(cfg_active));
endmodule

// [verilog/fdcr_top.sv]
`timescale 1ns/10ps
`include "fdcr_params.svh"
// Functional notes
// R01: all host registers eight bits wide
// R02: config pair at 3f0 or 370, write-only
// R03: floppy block disabled until base programmed
// R04: config writes only inside config state
// R05: enhanced bit selects alternate floppy mode
// R06: ident and encoding high give first mode
// R07: ident low encoding high give second mode
// R08: both low give third interface mode
// R09: eight offsets, shared read/write at four, seven
// R10: status_a readable in second and third modes
// R11: status_a read in first mode floats
// R12: bit 0 step direction, inward one
// R13: bit 1 write protect, forced protect clears
// R14: bits 2 and 4 index, track zero raw
// R15: bit 3 head side, one is side 1
// R16: bit 5 step output active high
// R17: bit 6 second drive present, low
// R18: bit 7 mirrors floppy interrupt output
// R19: writes to read-only offsets are dropped
module fdcr_top
  import fdcr_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       reset_n,
  input  wire logic       cfg_port_alt,
  input  wire logic [9:0] host_addr,
  input  wire logic [7:0] host_data_in,
  output logic      [7:0] host_data_out,
  output logic            host_data_oe,
  input  wire logic       host_ior_n,
  input  wire logic       host_iow_n,
  input  wire logic       host_aen,
  input  wire fdcr_disk_t disk_in,
  input  wire fdcr_core_t core_stat,
  input  wire logic [7:0] core_rd_data,
  output logic            core_rd_stb,
  output logic            core_wr_stb,
  output logic      [2:0] core_off,
  output logic      [7:0] core_wr_data,
  output logic            cfg_active,
  output logic            enh_floppy_mode,
  output fdcr_if_mode_t   if_mode,
  output logic            dma_enable_valid,
  output logic            irq_drq_driven,
  output logic            tc_active_high,
  output logic            density_select_high
);
  localparam int          SYNC_W   = 26;                // synchronised pin count
  localparam logic [25:0] SYNC_RST = {10'h000, 8'h00, 3'h7, 4'hf, 1'b0};

  logic [1:0]  rst_pipe;       // reset release chain
  logic        rst_n;          // released reset for the design
  logic [25:0] sync_q;         // synchronised pins
  logic [9:0]  addr_s;         // address after sync
  logic [7:0]  data_s;         // write data after sync
  logic        ior_n_s;        // read strobe after sync
  logic        iow_n_s;        // write strobe after sync
  logic        aen_s;          // dma address enable after sync
  fdcr_disk_t  disk_s;         // drive inputs after sync
  logic        port_alt_s;     // port strap after sync
  fdcr_cfg_t   cfg;            // decoded configuration
  fdcr_wr_t    wr_ev;          // committed write
  logic        iow_n_q, next_iow_n_q;   // previous write strobe
  logic        ior_n_q, next_ior_n_q;   // previous read strobe
  logic [9:0]  wr_addr_q, next_wr_addr_q; // address held during strobe
  logic [7:0]  wr_data_q, next_wr_data_q; // data held during strobe
  logic        aen_q, next_aen_q;       // aen held during strobe
  logic [9:0]  rd_addr_q, next_rd_addr_q; // read address held
  logic        rd_act;         // read strobe asserted
  logic        rd_hit;         // read targets floppy block
  logic        wr_hit;         // write targets floppy block
  logic        rd_end;         // read strobe released
  logic [2:0]  rd_off;         // offset being read
  logic [2:0]  wr_off;         // offset being written
  logic        wr_writable;    // offset takes writes
  logic [7:0]  stat_second;    // status_a, second mode layout
  logic [7:0]  stat_third;     // status_a, third mode layout
  logic        wp_eff_n;       // write protect after forcing
  logic        step_latch, next_step_latch; // latched step for third mode
  logic [7:0]  next_data_out;
  logic        next_data_oe;
  logic        next_rd_stb;
  logic        next_wr_stb;
  logic [2:0]  next_off;
  logic [7:0]  next_wr_data;

  // reset release through two flops
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      rst_pipe <= 2'b00;
    end else begin
      rst_pipe <= {rst_pipe[0], 1'b1};
    end
  end
  assign rst_n = rst_pipe[1];

  // every host, drive and strap pin crosses two flops before use
  fdcr_sync #(
    .W   (SYNC_W),
    .RST (SYNC_RST)
  ) u_sync (
    .mclk  (mclk),
    .rst_n (rst_n),
    .d     ({host_addr, host_data_in, host_ior_n, host_iow_n, host_aen,
             disk_in, cfg_port_alt}),
    .q     (sync_q)
  );

  // split synchronised bundle
  assign addr_s     = sync_q[25:16];
  assign data_s     = sync_q[15:8];
  assign ior_n_s    = sync_q[7];
  assign iow_n_s    = sync_q[6];
  assign aen_s      = sync_q[5];
  assign disk_s     = sync_q[4:1];
  assign port_alt_s = sync_q[0];

  // write commits when the strobe releases, using values held while low
  assign wr_ev.wr   = !iow_n_q && iow_n_s && !aen_q;
  assign wr_ev.addr = wr_addr_q;
  assign wr_ev.data = wr_data_q; // R01

  // configuration ports and registers
  fdcr_cfg u_cfg (
    .mclk       (mclk),
    .rst_n      (rst_n),
    .port_alt   (port_alt_s),
    .wr         (wr_ev),
    .cfg        (cfg),
    .cfg_active (cfg_active)
  );

  // floppy window decode, closed until a base is programmed
  assign rd_act = !ior_n_s && !aen_s;
  assign rd_off = addr_s[2:0];
  assign rd_hit = cfg.fdc_en && (addr_s[9:3] == cfg.base); // R03
  assign wr_off = wr_addr_q[2:0];
  assign wr_hit = wr_ev.wr && cfg.fdc_en && (wr_addr_q[9:3] == cfg.base); // R09
  assign rd_end = !ior_n_q && ior_n_s && cfg.fdc_en && (rd_addr_q[9:3] == cfg.base);

  // only these offsets take writes
  always_comb begin
    case (wr_off)
      `FDCR_OFF_DIGITAL_OUTPUT: wr_writable = 1'b1;
      `FDCR_OFF_TAPE_DRIVE:     wr_writable = 1'b1;
      `FDCR_OFF_MAIN_STATUS:    wr_writable = 1'b1; // R09
      `FDCR_OFF_DATA_PORT:      wr_writable = 1'b1;
      `FDCR_OFF_DIGITAL_INPUT:  wr_writable = 1'b1; // R09
      default:                  wr_writable = 1'b0; // R19
    endcase
  end

  // write protect with the forcing bit applied
  assign wp_eff_n = disk_s.write_protect_n && !cfg.force_wp; // R13

  // status_a in the second mode, drive pins as seen
  assign stat_second = {core_stat.floppy_irq_out,      // R18
                        disk_s.second_drive_present_n, // R17
                        core_stat.step_out,            // R16
                        disk_s.track_zero_n,           // R14
                        core_stat.head_side,           // R15
                        disk_s.index_n,                // R14
                        wp_eff_n,                      // R13
                        core_stat.head_inward};        // R12

  // status_a in the third mode, inverted pins
  assign stat_third = {core_stat.floppy_irq_out,
                       core_stat.drq,
                       step_latch,
                       !disk_s.track_zero_n,
                       !core_stat.head_side,
                       !disk_s.index_n,
                       !wp_eff_n,
                       !core_stat.head_inward}; // R10

  // strobe history, held address and data, step latch
  always_comb begin
    next_iow_n_q   = iow_n_s;
    next_ior_n_q   = ior_n_s;
    next_wr_addr_q = wr_addr_q;
    next_wr_data_q = wr_data_q;
    next_aen_q     = aen_q;
    next_rd_addr_q = rd_addr_q;
    // hold bus while strobes are low
    if (!iow_n_s) begin
      next_wr_addr_q = addr_s;
      next_wr_data_q = data_s;
      next_aen_q     = aen_s;
    end
    if (rd_act) begin
      next_rd_addr_q = addr_s;
    end
    // step latch set wins over the clear by digital_input read
    if (core_stat.step_out) begin
      next_step_latch = 1'b1;
    end else if (rd_end && rd_addr_q[2:0] == `FDCR_OFF_DIGITAL_INPUT) begin
      next_step_latch = 1'b0;
    end else begin
      next_step_latch = step_latch;
    end
  end

  // host data bus and core strobes
  always_comb begin
    next_data_out = host_data_out;
    next_data_oe  = 1'b0;
    next_rd_stb   = 1'b0;
    next_wr_stb   = 1'b0;
    next_off      = core_off;
    next_wr_data  = core_wr_data;
    // read in progress on the window
    if (rd_act && rd_hit) begin
      case (rd_off)
        `FDCR_OFF_STATUS_A: begin
          case (cfg.if_mode)
            FDCR_IF_SECOND: begin
              next_data_oe  = 1'b1; // R10
              next_data_out = stat_second;
            end
            FDCR_IF_THIRD: begin
              next_data_oe  = 1'b1; // R10
              next_data_out = stat_third;
            end
            default: next_data_oe = 1'b0; // R11
          endcase
        end
        `FDCR_OFF_RESERVED_SIX: next_data_oe = 1'b0; // R09
        default: begin
          // other registers come from the core
          next_data_oe  = 1'b1;
          next_data_out = core_rd_data;
          next_off      = rd_off;
        end
      endcase
    end
    // read finished, tell core which offset was read
    if (rd_end && rd_addr_q[2:0] != `FDCR_OFF_STATUS_A &&
        rd_addr_q[2:0] != `FDCR_OFF_RESERVED_SIX) begin
      next_rd_stb = 1'b1;
      next_off    = rd_addr_q[2:0];
    end
    // write passes on only to writable offsets
    if (wr_hit && wr_writable) begin
      next_wr_stb  = 1'b1; // R19
      next_off     = wr_off;
      next_wr_data = wr_data_q;
    end
  end

  // register bus side state
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      iow_n_q       <= 1'b1;
      ior_n_q       <= 1'b1;
      wr_addr_q     <= 10'h000;
      wr_data_q     <= 8'h00;
      aen_q         <= 1'b0;
      rd_addr_q     <= 10'h000;
      step_latch    <= 1'b0;
      host_data_out <= 8'h00;
      host_data_oe  <= 1'b0;
      core_rd_stb   <= 1'b0;
      core_wr_stb   <= 1'b0;
      core_off      <= 3'h0;
      core_wr_data  <= 8'h00;
    end else begin
      iow_n_q       <= next_iow_n_q;
      ior_n_q       <= next_ior_n_q;
      wr_addr_q     <= next_wr_addr_q;
      wr_data_q     <= next_wr_data_q;
      aen_q         <= next_aen_q;
      rd_addr_q     <= next_rd_addr_q;
      step_latch    <= next_step_latch;
      host_data_out <= next_data_out;
      host_data_oe  <= next_data_oe;
      core_rd_stb   <= next_rd_stb;
      core_wr_stb   <= next_wr_stb;
      core_off      <= next_off;
      core_wr_data  <= next_wr_data;
    end
  end

  // mode outputs to the rest of the controller
  assign enh_floppy_mode     = cfg.enh_floppy; // R05
  assign if_mode             = cfg.if_mode;
  assign dma_enable_valid    = (cfg.if_mode != FDCR_IF_SECOND); // R06
  assign irq_drq_driven      = (cfg.if_mode == FDCR_IF_SECOND); // R07
  assign tc_active_high      = (cfg.if_mode != FDCR_IF_SECOND); // R08
  assign density_select_high = (cfg.if_mode == FDCR_IF_FIRST);  // R06

  // first mode read of status_a leaves bus floating
  a_status_float: assert property (@(posedge mclk) disable iff (!rst_n) // R11
    (rd_act && rd_hit && rd_off == `FDCR_OFF_STATUS_A && cfg.if_mode == FDCR_IF_FIRST)
      |=> !host_data_oe)
    else $error("status_a drove bus in first mode");

  // direction bit follows core
  a_status_inward: assert property (@(posedge mclk) disable iff (!rst_n) // R12
    (rd_act && rd_hit && rd_off == `FDCR_OFF_STATUS_A && cfg.if_mode == FDCR_IF_SECOND)
      |=> host_data_oe && host_data_out[0] == $past(core_stat.head_inward))
    else $error("status_a bit 0 wrong");

  // forced protect reads as protected
  a_status_wp_force: assert property (@(posedge mclk) disable iff (!rst_n) // R13
    (rd_act && rd_hit && rd_off == `FDCR_OFF_STATUS_A && cfg.if_mode == FDCR_IF_SECOND
     && cfg.force_wp) |=> !host_data_out[1])
    else $error("forced write protect not shown");

  // head side and step bits
  a_status_head_step: assert property (@(posedge mclk) disable iff (!rst_n) // R15
    (rd_act && rd_hit && rd_off == `FDCR_OFF_STATUS_A && cfg.if_mode == FDCR_IF_SECOND)
      |=> host_data_out[3] == $past(core_stat.head_side)
          && host_data_out[5] == $past(core_stat.step_out))
    else $error("status_a head or step bit wrong");

  // interrupt bit mirrors interrupt output
  a_status_irq_bit: assert property (@(posedge mclk) disable iff (!rst_n) // R18
    (rd_act && rd_hit && rd_off == `FDCR_OFF_STATUS_A && cfg.if_mode != FDCR_IF_FIRST)
      |=> host_data_out[7] == $past(core_stat.floppy_irq_out))
    else $error("status_a bit 7 wrong");

  // no write reaches read-only or reserved offsets
  a_ro_write_drop: assert property (@(posedge mclk) disable iff (!rst_n) // R19
    core_wr_stb |-> core_off != `FDCR_OFF_STATUS_A && core_off != `FDCR_OFF_STATUS_B
                    && core_off != `FDCR_OFF_RESERVED_SIX)
    else $error("write passed to read-only offset");

  // second mode pin polarities
  a_second_mode_pins: assert property (@(posedge mclk) disable iff (!rst_n) // R07
    cfg.if_mode == FDCR_IF_SECOND |-> irq_drq_driven && !tc_active_high
                                   && !density_select_high && !dma_enable_valid)
    else $error("second mode pin controls wrong");

  // third mode polarities
  a_third_mode_pins: assert property (@(posedge mclk) disable iff (!rst_n) // R08
    cfg.if_mode == FDCR_IF_THIRD |-> tc_active_high && !density_select_high
                                   && dma_enable_valid && !irq_drq_driven)
    else $error("third mode pin controls wrong");

  // disabled window never drives bus
  a_off_no_drive: assert property (@(posedge mclk) disable iff (!rst_n) // R03
    !cfg.fdc_en ##1 !cfg.fdc_en |-> !host_data_oe)
    else $error("bus driven while block disabled");

  c_second_status_read: cover property (@(posedge mclk) disable iff (!rst_n)
    host_data_oe && cfg.if_mode == FDCR_IF_SECOND && rd_off == `FDCR_OFF_STATUS_A);
  c_first_status_read: cover property (@(posedge mclk) disable iff (!rst_n)
    rd_act && rd_hit && rd_off == `FDCR_OFF_STATUS_A && cfg.if_mode == FDCR_IF_FIRST);
  c_core_write: cover property (@(posedge mclk) disable iff (!rst_n) core_wr_stb);
endmodule

// [verification/fdcr_host_bfm.sv]
`timescale 1ns/10ps
// host side of the i/o bus, drives at the falling edge
module fdcr_host_bfm (
  input  wire logic       mclk,
  output logic      [9:0] addr,
  output logic      [7:0] din,
  output logic            ior_n,
  output logic            iow_n,
  output logic            aen,
  input  wire logic [7:0] dout,
  input  wire logic       oe
);
  // idle bus, never a dma cycle
  initial begin
    addr = 10'h000;
    din = 8'h00;
    ior_n = 1'b1;
    iow_n = 1'b1;
    aen = 1'b0;
  end
  // write: strobe low 4, then high 4 with address still held
  task automatic io_wr(input logic [9:0] a, input logic [7:0] d);
    @(negedge mclk) addr = a;
    din = d;
    iow_n = 1'b0;
    repeat (4) @(negedge mclk);
    iow_n = 1'b1;
    repeat (4) @(negedge mclk);
    din = ~d; // released data no longer shows last value
  endtask
  // read: answer taken while strobe still low
  task automatic io_rd(input logic [9:0] a, output logic [7:0] d, output logic o);
    @(negedge mclk) addr = a;
    ior_n = 1'b0;
    repeat (6) @(negedge mclk);
    d = dout;
    o = oe;
    ior_n = 1'b1;
    repeat (5) @(negedge mclk);
  endtask
endmodule

// [verification/testbench.sv]
`timescale 1ns/10ps
module testbench
  import fdcr_pkg::*;
;
  logic          mclk = 1'b0;
  logic          alt = 1'b0;
  logic          reset_n = 1'b0;
  logic    [9:0] addr;
  logic    [7:0] din, dout, rd, crd, wdat, d;
  logic          ior_n, iow_n, aen, oe, rstb, wstb, ro, cfga, enh, dv, dr, th, dh;
  logic    [2:0] off;
  logic   [10:0] last_wr;
  fdcr_disk_t    disk;
  fdcr_core_t    core;
  fdcr_if_mode_t mode;
  int            err_count = 0, checked = 0, wp = 0, rp = 0;
  logic    [2:0] mv [3] = '{3'b111, 3'b000, 3'b010}; // first, third, second
  logic    [3:0] fl [3] = '{4'hb, 4'ha, 4'h4};
  always #50 mclk = ~mclk;
  fdcr_top DUT (.mclk(mclk), .reset_n(reset_n), .cfg_port_alt(alt), .host_addr(addr),
    .host_data_in(din), .host_data_out(dout), .host_data_oe(oe), .host_ior_n(ior_n),
    .host_iow_n(iow_n), .host_aen(aen), .disk_in(disk), .core_stat(core),
    .core_rd_data(crd), .core_rd_stb(rstb), .core_wr_stb(wstb), .core_off(off),
    .core_wr_data(wdat), .cfg_active(cfga), .enh_floppy_mode(enh), .if_mode(mode),
    .dma_enable_valid(dv), .irq_drq_driven(dr), .tc_active_high(th),
    .density_select_high(dh));
  fdcr_host_bfm host (.mclk(mclk), .addr(addr), .din(din), .ior_n(ior_n), .iow_n(iow_n),
    .aen(aen), .dout(dout), .oe(oe));
  // record every core write pulse
  always @(posedge mclk) if (wstb === 1'b1) begin
    wp <= wp + 1;
    last_wr <= {off, wdat};
  end
  // count core read pulses
  always @(posedge mclk) if (rstb === 1'b1) rp <= rp + 1;
  task automatic chk(input logic [10:0] got, input logic [10:0] e);
    checked++;
    if (got !== e) begin
      err_count++;
      $display("MISMATCH %0t got %h exp %h", $time, got, e);
    end
  endtask
  task automatic cfg(input logic [7:0] idx, input logic [7:0] val);
    host.io_wr(10'h3f0, idx);
    host.io_wr(10'h3f1, val);
  endtask
  // reference status_a, second mode layout
  function automatic logic [7:0] exp_status(input logic f);
    return {core.floppy_irq_out, disk.second_drive_present_n, core.step_out,
      disk.track_zero_n, core.head_side, disk.index_n, disk.write_protect_n & ~f,
      core.head_inward};
  endfunction
  task give_verdict;
    $display("checked %0d err_count %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // watchdog
  initial begin
    repeat (20000) @(posedge mclk);
    err_count++;
    give_verdict;
  end
  initial begin
    disk = '1;
    core = '0;
    crd = 8'h00;
    void'($urandom(49));
    repeat (6) @(negedge mclk);
    reset_n = 1'b1;
    repeat (6) @(negedge mclk);
    host.io_rd(10'h3f8, rd, ro);
    chk(ro, 0);
    host.io_wr(10'h3f0, 8'h55);
    host.io_wr(10'h3f0, 8'h55);
    chk(cfga, 1);
    cfg(8'h20, 8'hfe);
    for (int i = 0; i < 3; i++) begin
      cfg(8'h03, {5'h0, mv[i]});
      chk(mode, {i == 1, i == 2, i == 0});
      chk(enh, mv[i][0]);
      chk({dv, dr, th, dh}, fl[i]);
      for (int k = 0; k < 4; k++) begin
        disk = 4'($urandom);
        core = 5'($urandom);
        host.io_rd(10'h3f8, rd, ro);
        chk(ro, i > 0);
        if (i == 2) chk(rd, exp_status(0));
      end
    end
    cfg(8'h17, 8'h01);
    host.io_rd(10'h3f8, rd, ro);
    chk(rd, exp_status(1));
    d = 8'($urandom);
    host.io_wr(10'h3f8, d);
    host.io_wr(10'h3f9, d);
    host.io_wr(10'h3fe, d);
    chk(wp, 0);
    host.io_wr(10'h3fa, d);
    chk(wp, 1);
    chk(last_wr, {3'h2, d});
    crd = 8'($urandom);
    host.io_rd(10'h3fc, rd, ro);
    chk({ro, rd}, {1'b1, crd});
    chk(rp, 1);
    host.io_rd(10'h3fe, rd, ro);
    chk(ro, 0);
    host.io_rd(10'h3f1, rd, ro);
    chk(ro, 0);
    host.io_wr(10'h3f0, 8'haa);
    chk(cfga, 0);
    cfg(8'h03, 8'h06);
    chk(mode, 3'b010);
    // second reset with the strap moved to the other port pair
    alt = 1'b1;
    reset_n = 1'b0;
    repeat (6) @(negedge mclk);
    reset_n = 1'b1;
    repeat (6) @(negedge mclk);
    host.io_rd(10'h3f8, rd, ro);
    chk({ro, mode}, {1'b0, 3'b001});
    host.io_wr(10'h3f0, 8'h55);
    host.io_wr(10'h3f0, 8'h55);
    chk(cfga, 0);
    host.io_wr(10'h370, 8'h55);
    host.io_wr(10'h370, 8'h55);
    chk(cfga, 1);
    give_verdict;
  end
endmodule
